// ---- src/operation_questionable_status.sv ----
/*
 Operation and questionable status structures with a command port.
 Assumes activity lines come from logic on sys_clk; the host side decodes
 queries into one-cycle read and write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module operation_questionable_status #(
   // Arbitrary default; selects the variant with the time bit
   parameter bit HAS_TIME_QUESTIONABLE = 1'b1
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        calibrating,
   input  wire logic        measuring,
   input  wire logic        waiting_trigger,
   input  wire logic        waiting_arm,
   input  wire logic        self_testing,
   input  wire logic [3:0]  probe_attached,
   input  wire logic        time_questionable,
   input  wire logic        calibration_needed,
   input  wire logic [3:0]  calculation_range_fault,
   input  wire logic        status_preset,
   input  wire logic        cmd_write,
   input  wire logic        cmd_read,
   input  wire logic        cmd_struct,
   input  wire logic [3:0]  cmd_sel,
   input  wire logic [15:0] cmd_wdata,
   output logic      [15:0] rd_data,
   output logic             rd_valid,
   output logic             operation_summary,
   output logic             questionable_summary,
   output logic             operation_queue_post,
   output logic             questionable_queue_post
);
   logic [15:0] op_condition_in;
   logic [15:0] qs_condition_in;
   logic [15:0] qs_used;
   logic [15:0] op_words [7];
   logic [15:0] qs_words [7];
   logic        op_summary_w;
   logic        qs_summary_w;
   logic        op_queue_w;
   logic        qs_queue_w;
   logic        op_wr;
   logic        qs_wr;
   logic        op_ev_read;
   logic        qs_ev_read;
   logic [15:0] rd_next;

   status_condition_map u_map (
      .calibrating     (calibrating),
      .measuring       (measuring),
      .waiting_trigger (waiting_trigger),
      .waiting_arm     (waiting_arm),
      .self_testing    (self_testing),
      .probe_attached  (probe_attached),
      .condition       (op_condition_in)
   );

   // Variant without the time bit keeps bit 2 unused
   assign qs_used = HAS_TIME_QUESTIONABLE ? status_pkg::QS_USED_MASK_A : status_pkg::QS_USED_MASK_B;

   always_comb begin
      qs_condition_in = 16'h0000;
      qs_condition_in[status_pkg::QS_TIME]        = time_questionable;
      qs_condition_in[status_pkg::QS_CALIBRATION] = calibration_needed;
      qs_condition_in[status_pkg::QS_CALC_FIRST +: status_pkg::PROBE_COUNT] = calculation_range_fault;
   end

   assign op_wr      = cmd_write && (cmd_struct == status_pkg::STRUCT_OPERATION);
   assign qs_wr      = cmd_write && (cmd_struct == status_pkg::STRUCT_QUESTIONABLE);
   // Only event selector reads have a side effect
   assign op_ev_read = cmd_read && (cmd_struct == status_pkg::STRUCT_OPERATION)
                       && (cmd_sel == status_pkg::SEL_EVENT);
   assign qs_ev_read = cmd_read && (cmd_struct == status_pkg::STRUCT_QUESTIONABLE)
                       && (cmd_sel == status_pkg::SEL_EVENT);

   status_structure u_operation (
      .sys_clk         (sys_clk),
      .rst_n           (rst_n),
      .used_mask       (status_pkg::OP_USED_MASK),
      .condition_in    (op_condition_in),
      .preset          (status_preset),
      .wr_en           (op_wr),
      .sel             (cmd_sel),
      .wr_data         (cmd_wdata),
      .event_read      (op_ev_read),
      .event_word      (op_words[0]),
      .condition_word  (op_words[1]),
      .rise_word       (op_words[2]),
      .fall_word       (op_words[3]),
      .summary_word    (op_words[4]),
      .queue_rise_word (op_words[5]),
      .queue_fall_word (op_words[6]),
      .summary_bit     (op_summary_w),
      .queue_post      (op_queue_w)
   );

   status_structure u_questionable (
      .sys_clk         (sys_clk),
      .rst_n           (rst_n),
      .used_mask       (qs_used),
      .condition_in    (qs_condition_in),
      .preset          (status_preset),
      .wr_en           (qs_wr),
      .sel             (cmd_sel),
      .wr_data         (cmd_wdata),
      .event_read      (qs_ev_read),
      .event_word      (qs_words[0]),
      .condition_word  (qs_words[1]),
      .rise_word       (qs_words[2]),
      .fall_word       (qs_words[3]),
      .summary_word    (qs_words[4]),
      .queue_rise_word (qs_words[5]),
      .queue_fall_word (qs_words[6]),
      .summary_bit     (qs_summary_w),
      .queue_post      (qs_queue_w)
   );

   // Unknown selectors read zero
   always_comb begin
      rd_next = 16'h0000;
      if (cmd_sel < 4'h7) begin
         if (cmd_struct == status_pkg::STRUCT_OPERATION) begin
            rd_next = op_words[cmd_sel[2:0]];
         end else begin
            rd_next = qs_words[cmd_sel[2:0]];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data  <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= cmd_read;
         if (cmd_read) begin
            rd_data <= rd_next;
         end
      end
   end

   // Summary bits one stage late so outputs come from flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         operation_summary       <= 1'b0;
         questionable_summary    <= 1'b0;
         operation_queue_post    <= 1'b0;
         questionable_queue_post <= 1'b0;
      end else begin
         operation_summary       <= op_summary_w;
         questionable_summary    <= qs_summary_w;
         operation_queue_post    <= op_queue_w;
         questionable_queue_post <= qs_queue_w;
      end
   end

   a_op_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((op_words[0] & op_words[4]) != 16'h0000) |-> ##2 operation_summary)
      else $error("Operation summary missing");
   a_qs_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((qs_words[0] & qs_words[4]) == 16'h0000) |-> ##2 !questionable_summary)
      else $error("Questionable summary spurious");
   a_read_return: assert property (@(posedge sys_clk) disable iff (!rst_n)
      op_ev_read |=> (rd_valid && rd_data == $past(op_words[0])))
      else $error("Operation read value wrong");
   a_cond_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cmd_read && cmd_struct == status_pkg::STRUCT_OPERATION && cmd_sel == status_pkg::SEL_CONDITION)
      |=> (rd_data == $past(op_words[1])))
      else $error("Condition read wrong");
   // Checked on both variants, so the default build exercises it too
   a_qs_bit_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (qs_words[1][status_pkg::QS_TIME] == (HAS_TIME_QUESTIONABLE && $past(time_questionable))))
      else $error("Time bit wrong for variant");
endmodule // operation_questionable_status
`default_nettype wire

// ---- src/status_condition_map.sv ----
/*
 Builds the operation condition word from individual activity lines.
 Assumes all inputs are already synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module status_condition_map (
   input  wire logic        calibrating,
   input  wire logic        measuring,
   input  wire logic        waiting_trigger,
   input  wire logic        waiting_arm,
   input  wire logic        self_testing,
   input  wire logic [3:0]  probe_attached,
   output logic      [15:0] condition
);
   always_comb begin
      condition = 16'h0000;
      condition[status_pkg::OP_CALIBRATING] = calibrating;
      condition[status_pkg::OP_TESTING]     = self_testing;
      condition[status_pkg::OP_MEASURING]   = measuring;
      condition[status_pkg::OP_WAIT_TRIG]   = waiting_trigger;
      condition[status_pkg::OP_WAIT_ARM]    = waiting_arm;
      condition[status_pkg::OP_PROBE_FIRST +: status_pkg::PROBE_COUNT] = probe_attached;
   end
endmodule // status_condition_map
`default_nettype wire

// ---- src/status_pkg.sv ----
/*
 Shared constants for the operation and questionable status structures:
 register selectors, bit positions, preset values and masks of used bits.
 Assumes a single clock domain and a simple command port in the top module.
*/
package status_pkg;
   localparam int unsigned WIDTH = 16;

   // Register selectors on the command port
   localparam logic [3:0] SEL_EVENT      = 4'h0;
   localparam logic [3:0] SEL_CONDITION  = 4'h1;
   localparam logic [3:0] SEL_RISE       = 4'h2;
   localparam logic [3:0] SEL_FALL       = 4'h3;
   localparam logic [3:0] SEL_SUMMARY    = 4'h4;
   localparam logic [3:0] SEL_QUEUE_RISE = 4'h5;
   localparam logic [3:0] SEL_QUEUE_FALL = 4'h6;

   // Structure selector
   localparam logic STRUCT_OPERATION    = 1'b0;
   localparam logic STRUCT_QUESTIONABLE = 1'b1;

   // Operation bit positions
   localparam int unsigned OP_CALIBRATING = 0;
   localparam int unsigned OP_MEASURING   = 4;
   localparam int unsigned OP_WAIT_TRIG   = 5;
   localparam int unsigned OP_WAIT_ARM    = 6;
   localparam int unsigned OP_TESTING     = 8;
   localparam int unsigned OP_PROBE_FIRST = 9;

   // Questionable bit positions
   localparam int unsigned QS_TIME        = 2;
   localparam int unsigned QS_CALIBRATION = 8;
   localparam int unsigned QS_CALC_FIRST  = 9;

   localparam int unsigned PROBE_COUNT = 4;

   // Used bits of each structure
   localparam logic [15:0] OP_USED_MASK   = 16'h1F71;
   localparam logic [15:0] QS_USED_MASK_A = 16'h1F04;
   localparam logic [15:0] QS_USED_MASK_B = 16'h1F00;

   // Preset and reset values
   localparam logic [15:0] RISE_PRESET  = 16'hFFFF;
   localparam logic [15:0] FALL_PRESET  = 16'h0000;
   localparam logic [15:0] MASK_PRESET  = 16'h0000;
   localparam logic [15:0] EVENT_RESET  = 16'h0000;

   // Status byte summary bit positions
   localparam int unsigned STB_OPERATION    = 7;
   localparam int unsigned STB_QUESTIONABLE = 3;
endpackage

// ---- src/status_structure.sv ----
/*
 One event reporting structure: condition, filters, sticky event word,
 summary mask and queue masks. Assumes synchronous condition input.
*/
`timescale 1ns/1ps
`default_nettype none
module status_structure (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] used_mask,
   input  wire logic [15:0] condition_in,
   input  wire logic        preset,
   input  wire logic        wr_en,
   input  wire logic [3:0]  sel,
   input  wire logic [15:0] wr_data,
   input  wire logic        event_read,
   output logic      [15:0] event_word,
   output logic      [15:0] condition_word,
   output logic      [15:0] rise_word,
   output logic      [15:0] fall_word,
   output logic      [15:0] summary_word,
   output logic      [15:0] queue_rise_word,
   output logic      [15:0] queue_fall_word,
   output logic             summary_bit,
   output logic             queue_post
);
   logic [15:0] cond_prev_reg;
   logic [15:0] cond_reg;
   logic [15:0] event_reg;
   logic [15:0] rise_reg;
   logic [15:0] fall_reg;
   logic [15:0] summary_reg;
   logic [15:0] queue_rise_reg;
   logic [15:0] queue_fall_reg;
   logic [15:0] rose;
   logic [15:0] fell;
   logic [15:0] latch_set;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_reg      <= 16'h0000;
         cond_prev_reg <= 16'h0000;
      end else begin
         cond_reg      <= condition_in & used_mask;
         cond_prev_reg <= cond_reg;
      end
   end

   assign rose      = cond_reg & ~cond_prev_reg;
   assign fell      = ~cond_reg & cond_prev_reg;
   assign latch_set = ((rose & rise_reg) | (fell & fall_reg)) & used_mask;

   // New edges win over the clearing read so no event is lost
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_reg <= status_pkg::EVENT_RESET;
      end else if (event_read) begin
         event_reg <= latch_set;
      end else begin
         event_reg <= event_reg | latch_set;
      end
   end

   // Preset touches masks only, never event or condition
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_reg       <= status_pkg::RISE_PRESET;
         fall_reg       <= status_pkg::FALL_PRESET;
         summary_reg    <= status_pkg::MASK_PRESET;
         queue_rise_reg <= status_pkg::MASK_PRESET;
         queue_fall_reg <= status_pkg::MASK_PRESET;
      end else if (preset) begin
         rise_reg       <= status_pkg::RISE_PRESET;
         fall_reg       <= status_pkg::FALL_PRESET;
         summary_reg    <= status_pkg::MASK_PRESET;
         queue_rise_reg <= status_pkg::MASK_PRESET;
         queue_fall_reg <= status_pkg::MASK_PRESET;
      end else if (wr_en) begin
         if (sel == status_pkg::SEL_RISE) begin
            rise_reg <= wr_data;
         end else if (sel == status_pkg::SEL_FALL) begin
            fall_reg <= wr_data;
         end else if (sel == status_pkg::SEL_SUMMARY) begin
            summary_reg <= wr_data;
         end else if (sel == status_pkg::SEL_QUEUE_RISE) begin
            queue_rise_reg <= wr_data;
         end else if (sel == status_pkg::SEL_QUEUE_FALL) begin
            queue_fall_reg <= wr_data;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         summary_bit <= 1'b0;
         queue_post  <= 1'b0;
      end else begin
         summary_bit <= |(event_reg & summary_reg & used_mask);
         queue_post  <= |(((rose & queue_rise_reg) | (fell & queue_fall_reg)) & used_mask);
      end
   end

   assign event_word      = event_reg;
   assign condition_word  = cond_reg;
   assign rise_word       = rise_reg;
   assign fall_word       = fall_reg;
   assign summary_word    = summary_reg;
   assign queue_rise_word = queue_rise_reg;
   assign queue_fall_word = queue_fall_reg;

   a_edge_latches: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (latch_set != 16'h0000) |=> ((event_reg & $past(latch_set)) == $past(latch_set)))
      else $error("Filtered edge not latched");
   a_sticky_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!event_read && !preset) |=> ((event_reg & $past(event_reg)) == $past(event_reg)))
      else $error("Latched bit dropped without read");
   a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
      event_read |=> (event_reg == $past(latch_set)))
      else $error("Event read did not clear");
   a_preset_masks: assert property (@(posedge sys_clk) disable iff (!rst_n)
      preset |=> (rise_reg == 16'hFFFF && fall_reg == 16'h0000 && summary_reg == 16'h0000
                  && queue_rise_reg == 16'h0000 && queue_fall_reg == 16'h0000))
      else $error("Preset mask values wrong");
   a_preset_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (preset && !event_read && latch_set == 16'h0000) |=> $stable(event_reg))
      else $error("Preset altered event word");
   a_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((event_reg | cond_reg) & ~used_mask) == 16'h0000)
      else $error("Unused bit set");
   a_summary_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ##1 summary_bit == |($past(event_reg) & $past(summary_reg) & used_mask))
      else $error("Summary bit mismatch");
   a_queue_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((rose & queue_rise_reg & used_mask) != 16'h0000) |=> queue_post)
      else $error("Rising edge not posted");
   a_queue_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((fell & queue_fall_reg & used_mask) != 16'h0000) |=> queue_post)
      else $error("Falling edge not posted");
endmodule // status_structure
`default_nettype wire

// ---- test/operation_questionable_status_tb_top.sv ----
/*
 Self-checking bench for the status structures, driven through the host model.
 Assumes the command timing of the host model and line-to-event latency under 5 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module operation_questionable_status_tb_top;
   logic        sys_clk, rst_n, calibrating, measuring, waiting_trigger, waiting_arm;
   logic        self_testing, time_questionable, calibration_needed;
   logic [3:0]  probe_attached, calculation_range_fault;
   logic        status_preset, cmd_write, cmd_read, cmd_struct;
   logic [3:0]  cmd_sel;
   logic [15:0] cmd_wdata, rd_data, v, rd_data_b;
   logic        rd_valid, op_sum, qs_sum, op_post, qs_post;
   int          fails, tests_run, op_posts, qs_posts;

   operation_questionable_status #(.HAS_TIME_QUESTIONABLE(1'b1)) uut (
      .sys_clk, .rst_n, .calibrating, .measuring, .waiting_trigger, .waiting_arm,
      .self_testing, .probe_attached, .time_questionable, .calibration_needed,
      .calculation_range_fault, .status_preset, .cmd_write, .cmd_read, .cmd_struct,
      .cmd_sel, .cmd_wdata, .rd_data, .rd_valid, .operation_summary(op_sum),
      .questionable_summary(qs_sum), .operation_queue_post(op_post),
      .questionable_queue_post(qs_post));

   // Variant without the time bit, fed the same commands and lines
   operation_questionable_status #(.HAS_TIME_QUESTIONABLE(1'b0)) uut_b (
      .sys_clk, .rst_n, .calibrating, .measuring, .waiting_trigger, .waiting_arm,
      .self_testing, .probe_attached, .time_questionable, .calibration_needed,
      .calculation_range_fault, .status_preset, .cmd_write, .cmd_read, .cmd_struct,
      .cmd_sel, .cmd_wdata, .rd_data(rd_data_b), .rd_valid(), .operation_summary(),
      .questionable_summary(), .operation_queue_post(), .questionable_queue_post());

   status_host host (.sys_clk, .rd_data, .rd_valid, .status_preset, .cmd_write,
      .cmd_read, .cmd_struct, .cmd_sel, .cmd_wdata);

   always #5 sys_clk = ~sys_clk;

   // Pulses launch on the rising edge, so count them mid-cycle
   always @(negedge sys_clk) begin
      if (op_post === 1'b1) op_posts++;
      if (qs_post === 1'b1) qs_posts++;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdc(input string what, input logic s, input logic [3:0] a, input logic [15:0] exp);
      host.rd(s, a, v);
      check(what, exp, v);
   endtask

   // Lines given as a condition-shaped word, then time to latch
   task automatic set_op(input logic [15:0] w);
      @(negedge sys_clk);
      calibrating = w[0];
      measuring = w[4];
      waiting_trigger = w[5];
      waiting_arm = w[6];
      self_testing = w[8];
      probe_attached = w[12:9];
      repeat (6) @(negedge sys_clk);
   endtask

   task automatic set_qs(input logic [15:0] w);
      @(negedge sys_clk);
      time_questionable = w[2];
      calibration_needed = w[8];
      calculation_range_fault = w[12:9];
      repeat (6) @(negedge sys_clk);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Whole run is well under 2000 cycles
   initial begin
      #100000;
      fails++;
      summarize();
   end

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      fails = 0;
      tests_run = 0;
      op_posts = 0;
      qs_posts = 0;
      calibrating = 1'b0;
      measuring = 1'b0;
      waiting_trigger = 1'b0;
      waiting_arm = 1'b0;
      self_testing = 1'b0;
      probe_attached = 4'h0;
      time_questionable = 1'b0;
      calibration_needed = 1'b0;
      calculation_range_fault = 4'h0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      for (int s = 0; s < 2; s++)
         for (int a = 0; a < 8; a++)
            rdc("reset word", 1'(s), 4'(a), (a == 2) ? 16'hFFFF : 16'h0000);
      $display("test reset_values done");

      set_op(16'h0301);
      rdc("op condition", 1'b0, status_pkg::SEL_CONDITION, 16'h0301);
      rdc("op condition", 1'b0, status_pkg::SEL_CONDITION, 16'h0301);
      rdc("op event", 1'b0, status_pkg::SEL_EVENT, 16'h0301);
      rdc("op event", 1'b0, status_pkg::SEL_EVENT, 16'h0000);
      set_op(16'hFFFF);
      rdc("op condition", 1'b0, status_pkg::SEL_CONDITION, 16'h1F71);
      rdc("op event", 1'b0, status_pkg::SEL_EVENT, 16'h1C70);
      set_op(16'h0000);
      rdc("op event", 1'b0, status_pkg::SEL_EVENT, 16'h0000);
      $display("test op_lines done");

      host.wr(1'b0, status_pkg::SEL_FALL, 16'hFFFF);
      host.wr(1'b0, status_pkg::SEL_RISE, 16'h0000);
      set_op(16'h0010);
      set_op(16'h0000);
      set_op(16'h0010);
      rdc("op fall word", 1'b0, status_pkg::SEL_FALL, 16'hFFFF);
      host.wr(1'b0, status_pkg::SEL_SUMMARY, 16'h0010);
      repeat (6) @(negedge sys_clk);
      check("op summary", 16'h0001, {15'h0000, op_sum});
      host.wr(1'b0, status_pkg::SEL_SUMMARY, 16'h0001);
      repeat (6) @(negedge sys_clk);
      check("op summary", 16'h0000, {15'h0000, op_sum});
      rdc("op event", 1'b0, status_pkg::SEL_EVENT, 16'h0010);
      $display("test filters_summary done");

      host.wr(1'b0, status_pkg::SEL_QUEUE_RISE, 16'h0100);
      host.wr(1'b0, status_pkg::SEL_QUEUE_FALL, 16'h0100);
      set_op(16'h0100);
      check("op posts", 16'h0001, 16'(op_posts));
      set_op(16'h0000);
      check("op posts", 16'h0002, 16'(op_posts));
      host.wr(1'b0, status_pkg::SEL_QUEUE_FALL, 16'h0000);
      set_op(16'h0100);
      set_op(16'h0000);
      check("op posts", 16'h0003, 16'(op_posts));
      $display("test queue done");

      host.pre();
      for (int a = 2; a < 7; a++)
         rdc("preset word", 1'b0, 4'(a), (a == 2) ? 16'hFFFF : 16'h0000);
      rdc("op event", 1'b0, status_pkg::SEL_EVENT, 16'h0110);
      rdc("op condition", 1'b0, status_pkg::SEL_CONDITION, 16'h0000);
      $display("test preset done");

      set_qs(16'h1304);
      rdc("qs condition", 1'b1, status_pkg::SEL_CONDITION, 16'h1304);
      check("variant qs condition", 16'h1300, rd_data_b);
      rdc("qs event", 1'b1, status_pkg::SEL_EVENT, 16'h1304);
      check("variant qs event", 16'h1300, rd_data_b);
      rdc("qs event", 1'b1, status_pkg::SEL_EVENT, 16'h0000);
      set_qs(16'h0000);
      host.wr(1'b1, status_pkg::SEL_SUMMARY, 16'h0100);
      host.wr(1'b1, status_pkg::SEL_QUEUE_RISE, 16'h0200);
      set_qs(16'h0300);
      check("qs summary", 16'h0001, {15'h0000, qs_sum});
      check("qs posts", 16'h0001, 16'(qs_posts));
      rdc("qs event", 1'b1, status_pkg::SEL_EVENT, 16'h0300);
      repeat (6) @(negedge sys_clk);
      check("qs summary", 16'h0000, {15'h0000, qs_sum});
      $display("test questionable done");
      summarize();
   end
endmodule // operation_questionable_status_tb_top
`default_nettype wire

// ---- test/status_host.sv ----
/*
 Host controller model: issues one-cycle command strobes and collects
 read answers. Assumes the device takes commands on rising sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module status_host (
   input  wire logic        sys_clk,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid,
   output logic             status_preset,
   output logic             cmd_write,
   output logic             cmd_read,
   output logic             cmd_struct,
   output logic      [3:0]  cmd_sel,
   output logic      [15:0] cmd_wdata
);
   initial begin
      status_preset = 1'b0;
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      cmd_struct = 1'b0;
      cmd_sel = 4'h0;
      cmd_wdata = 16'h0000;
   end

   task automatic wr(input logic s, input logic [3:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      cmd_struct = s;
      cmd_sel = a;
      cmd_wdata = d;
      cmd_write = 1'b1;
      @(negedge sys_clk);
      cmd_write = 1'b0;
      // Stale data inverted so nothing relies on it after the strobe
      cmd_wdata = ~d;
   endtask

   task automatic rd(input logic s, input logic [3:0] a, output logic [15:0] d);
      int n;
      d = 'x;
      @(negedge sys_clk);
      cmd_struct = s;
      cmd_sel = a;
      cmd_read = 1'b1;
      @(negedge sys_clk);
      cmd_read = 1'b0;
      for (n = 0; n < 4 && rd_valid !== 1'b1; n++) @(negedge sys_clk);
      // Unknown result on a missing answer, so the compare fails
      if (rd_valid === 1'b1) d = rd_data;
   endtask

   task automatic pre();
      @(negedge sys_clk);
      status_preset = 1'b1;
      @(negedge sys_clk);
      status_preset = 1'b0;
   endtask
endmodule // status_host
`default_nettype wire
